// >>> rtl/lom_pkg.sv
package lom_pkg;
  // Geometry
  localparam int NCH     = 8;
  localparam int DAC_W   = 14;
  localparam int REG_W   = 16;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 12;
  localparam int IDX_W   = ADDR_W - 2;
  localparam int CNT_W   = 32;
  localparam int CH_W    = 3;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CHAN_FIRST = 10'h000;
  localparam logic [IDX_W-1:0] IDX_CHAN_LAST  = 10'h007;
  localparam logic [IDX_W-1:0] IDX_DATA_LAST  = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_LOOP_FAULT = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_CFG_STAT   = 10'h00d;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 10'h010;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h011;

  // Configuration / status field positions
  localparam int CFG_BIT   = 0;
  localparam int ERR_BIT   = 1;
  localparam int TSEL_LSB  = 2;
  localparam int TSEL_W    = 3;
  localparam int TACT_BIT  = 5;
  localparam int HWERR_BIT = 8;
  localparam int FPWR_BIT  = 14;

  // Reset values
  localparam logic [TSEL_W-1:0] TSEL_RST = 3'h0;
  localparam logic [DAC_W-1:0]  CODE_ZERO = 14'h0000;

  // Interrupt event bits
  localparam int IRQ_W      = 4;
  localparam int EV_TMO     = 0;
  localparam int EV_ATTN    = 1;
  localparam int EV_OPEN    = 2;
  localparam int EV_FPWR    = 3;

  // Timing
  localparam int CLK_HZ     = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int REFRESH_MS = 24;

  // Timeout period in ms for each select code
  function automatic logic [CNT_W-1:0] tmo_ms(input logic [TSEL_W-1:0] sel);
    logic [CNT_W-1:0] v;
    case (sel)
      3'h0:    v = 32'd16000;
      3'h1:    v = 32'd4000;
      3'h2:    v = 32'd2000;
      3'h3:    v = 32'd1000;
      3'h4:    v = 32'd500;
      3'h5:    v = 32'd250;
      3'h6:    v = 32'd125;
      default: v = 32'd62;
    endcase
    return v;
  endfunction : tmo_ms
endpackage : lom_pkg

// >>> rtl/lom_loop_chk.sv
`timescale 1ns/1ps
// Open-loop check of one channel: at each refresh the readback is held against the
// code commanded at the previous refresh, then the new code is remembered.
module lom_loop_chk (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Refresh of this channel
  input  wire logic                        chk_en,
  input  wire logic [lom_pkg::DAC_W-1:0]   cmd_code,
  input  wire logic [lom_pkg::DAC_W-1:0]   readback,
  input  wire logic [lom_pkg::DAC_W-1:0]   deadband,
  // Result
  output logic                             fail
);
  import lom_pkg::*;

  logic [DAC_W-1:0] last_r;
  logic [DAC_W-1:0] last_nxt;
  logic             fail_r;
  logic             fail_nxt;
  logic [DAC_W-1:0] diff;

  // Distance between wanted and measured current
  always_comb begin
    diff     = (readback > last_r) ? DAC_W'(readback - last_r) : DAC_W'(last_r - readback);
    last_nxt = last_r;
    fail_nxt = fail_r;
    if (chk_en) begin
      fail_nxt = (diff > deadband); // RULE9
      last_nxt = cmd_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= CODE_ZERO;
      fail_r <= 1'b0;
    end else begin
      last_r <= last_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign fail = fail_r;
endmodule : lom_loop_chk

// >>> rtl/lom_top.sv
`timescale 1ns/1ps
// Contract
// (RULE1) A write to index 13 loads configuration and a read there returns status.
// (RULE2) Bit 0 written one configures the module and reads back the configured state.
// (RULE3) Bit 1 written one forces the error state; it reads one on forced or internal error.
// (RULE4) Bits 4:2 select the controller communication timeout.
// (RULE5) Bit 5 selects what the outputs do on a communication timeout.
// (RULE6) The controller writes zero to bits 6 and 7, which are kept for factory test.
// (RULE7) Every one of the eight channels is refreshed once per 24 ms.
// (RULE8) Each channel converter receives a 14-bit code.
// (RULE9) Open-loop detection keeps eight pass/fail bits readable at index 12.
// (RULE10) On timeout, bit 5 set holds the last values, clear drives zero codes.
// (RULE11) Codes 0..7 give 16 s, 4 s, 2 s, 1 s, 500, 250, 125, 62 ms; 16 s after reset.
// (RULE12) Status bit 8 is set by any of the four hardware fault indications.
// (RULE13) While unconfigured, accesses to indices 0..11 produce an attention status.
// (RULE14) Status bit 14 shows field power failure; bits 9..13 and 15 read zero.
module lom_top #(
  parameter int CYC_PER_MS = lom_pkg::CYC_PER_MS
) (
  // APB slave
  input  wire logic                                        pclk,
  input  wire logic                                        presetn,
  input  wire logic                                        psel,
  input  wire logic                                        penable,
  input  wire logic                                        pwrite,
  input  wire logic [lom_pkg::ADDR_W-1:0]                  paddr,
  input  wire logic [lom_pkg::DATA_W-1:0]                  pwdata,
  output logic      [lom_pkg::DATA_W-1:0]                  prdata,
  output logic                                             pready,
  output logic                                             pslverr,
  // Fault indications
  input  wire logic                                        logic_load_fail,
  input  wire logic                                        nv_csum_bad,
  input  wire logic                                        prog_csum_bad,
  input  wire logic                                        mem_diag_fail,
  input  wire logic                                        field_pwr_fail,
  // Converter and readback
  output logic      [lom_pkg::DAC_W-1:0]                   dac_code,
  output logic      [lom_pkg::CH_W-1:0]                    dac_chan,
  output logic                                             dac_load,
  input  wire logic [lom_pkg::NCH-1:0][lom_pkg::DAC_W-1:0] readback,
  input  wire logic [lom_pkg::DAC_W-1:0]                   deadband,
  // Status
  output logic                                             comm_timeout,
  output logic                                             irq
);
  import lom_pkg::*;

  localparam int STEP_CYC = REFRESH_MS * CYC_PER_MS / NCH;

  // Bus decode
  logic             acc;
  logic             wr;
  logic [IDX_W-1:0] idx;
  logic             is_data;
  logic             attn;
  logic             mapped;

  // State
  logic [DAC_W-1:0]  chan_r [NCH];
  logic [DAC_W-1:0]  chan_nxt [NCH];
  logic              cfg_r, cfg_nxt;
  logic              ferr_r, ferr_nxt;
  logic [TSEL_W-1:0] tsel_r, tsel_nxt;
  logic              tact_r, tact_nxt;
  logic [CNT_W-1:0]  tcnt_r, tcnt_nxt;
  logic              tmo_r, tmo_nxt;
  logic [CNT_W-1:0]  scnt_r, scnt_nxt;
  logic [CH_W-1:0]   ch_r, ch_nxt;
  logic [DAC_W-1:0]  code_r, code_nxt;
  logic [CH_W-1:0]   dch_r, dch_nxt;
  logic              load_r, load_nxt;
  logic [IRQ_W-1:0]  ist_r, ist_nxt;
  logic [IRQ_W-1:0]  imsk_r, imsk_nxt;
  logic [NCH-1:0]    fail_w;
  logic [NCH-1:0]    fail_q_r;
  logic              fpwr_q_r;
  logic [IRQ_W-1:0]  ev;
  logic [REG_W-1:0]  stat_w;
  logic              hw_err;

  // Zero wait states: every access completes in its access phase
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign idx     = paddr[ADDR_W-1:2];
  assign is_data = (idx <= IDX_DATA_LAST);
  assign attn    = acc && is_data && !cfg_r; // RULE13
  assign mapped  = is_data || (idx == IDX_LOOP_FAULT) || (idx == IDX_CFG_STAT) ||
                   (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);
  assign pready  = 1'b1;
  assign pslverr = acc && (!mapped || attn);

  // Hardware error summary and status word
  assign hw_err = logic_load_fail || nv_csum_bad || prog_csum_bad || mem_diag_fail; // RULE12
  always_comb begin
    stat_w                          = '0; // RULE14
    stat_w[CFG_BIT]                 = cfg_r; // RULE2
    stat_w[ERR_BIT]                 = ferr_r || tmo_r || hw_err; // RULE3
    stat_w[TSEL_LSB +: TSEL_W]      = tsel_r;
    stat_w[TACT_BIT]                = tact_r;
    stat_w[HWERR_BIT]               = hw_err; // RULE12
    stat_w[FPWR_BIT]                = field_pwr_fail; // RULE14
  end

  // Read mux; a read restarts the watchdog and, while unconfigured, raises attention at indices 0..11
  always_comb begin
    prdata = '0;
    if (acc && !pwrite && !attn) begin
      if (idx <= IDX_CHAN_LAST) begin
        prdata[DAC_W-1:0] = chan_r[idx[CH_W-1:0]];
      end else if (idx == IDX_LOOP_FAULT) begin
        prdata[NCH-1:0] = fail_w; // RULE9
      end else if (idx == IDX_CFG_STAT) begin
        prdata[REG_W-1:0] = stat_w; // RULE1
      end else if (idx == IDX_IRQ_STAT) begin
        prdata[IRQ_W-1:0] = ist_r;
      end else if (idx == IDX_IRQ_MASK) begin
        prdata[IRQ_W-1:0] = imsk_r;
      end
    end
  end

  // Configuration and channel values; bits 6 and 7 are not stored at all
  always_comb begin
    cfg_nxt  = cfg_r;
    ferr_nxt = ferr_r;
    tsel_nxt = tsel_r;
    tact_nxt = tact_r;
    imsk_nxt = imsk_r;
    for (int i = 0; i < NCH; i++) begin
      chan_nxt[i] = chan_r[i];
    end
    if (wr && idx == IDX_CFG_STAT) begin // RULE1
      cfg_nxt  = pwdata[CFG_BIT]; // RULE2
      ferr_nxt = pwdata[ERR_BIT]; // RULE3
      tsel_nxt = pwdata[TSEL_LSB +: TSEL_W]; // RULE4
      tact_nxt = pwdata[TACT_BIT]; // RULE5
    end
    if (wr && !attn && idx <= IDX_CHAN_LAST) begin
      chan_nxt[idx[CH_W-1:0]] = pwdata[DAC_W-1:0]; // RULE8
    end
    if (wr && idx == IDX_IRQ_MASK) begin
      imsk_nxt = pwdata[IRQ_W-1:0];
    end
  end

  // Communication watchdog: any completed transfer restarts it
  always_comb begin
    tcnt_nxt = tcnt_r;
    tmo_nxt  = tmo_r;
    if (acc || !cfg_r) begin
      tcnt_nxt = '0;
      tmo_nxt  = 1'b0;
    end else if (!tmo_r) begin
      if (tcnt_r >= CNT_W'(tmo_ms(tsel_r) * CNT_W'(CYC_PER_MS)) - 1) begin // RULE11
        tmo_nxt = 1'b1;
      end else begin
        tcnt_nxt = tcnt_r + 1'b1;
      end
    end
  end

  // Refresh sequencer: one channel every 3 ms
  always_comb begin
    scnt_nxt = scnt_r + 1'b1;
    ch_nxt   = ch_r;
    code_nxt = code_r;
    dch_nxt  = dch_r;
    load_nxt = 1'b0;
    if (scnt_r >= CNT_W'(STEP_CYC - 1)) begin // RULE7
      scnt_nxt = '0;
      ch_nxt   = ch_r + 1'b1;
      dch_nxt  = ch_r;
      load_nxt = 1'b1;
      // Zero output only when unconfigured or timed out without hold
      code_nxt = (!cfg_r || (tmo_r && !tact_r)) ? CODE_ZERO : chan_r[ch_r]; // RULE10
    end
  end

  // Interrupt events; a new event beats a simultaneous clear
  assign ev[EV_TMO]  = tmo_nxt && !tmo_r;
  assign ev[EV_ATTN] = attn;
  assign ev[EV_OPEN] = |(fail_w & ~fail_q_r);
  assign ev[EV_FPWR] = field_pwr_fail && !fpwr_q_r;
  always_comb begin
    ist_nxt = ist_r;
    if (wr && idx == IDX_IRQ_STAT) begin
      ist_nxt = ist_r & ~pwdata[IRQ_W-1:0];
    end
    ist_nxt = ist_nxt | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        chan_r[i] <= CODE_ZERO;
      end
      cfg_r    <= 1'b0;
      ferr_r   <= 1'b0;
      tsel_r   <= TSEL_RST; // RULE11
      tact_r   <= 1'b0;
      tcnt_r   <= '0;
      tmo_r    <= 1'b0;
      scnt_r   <= '0;
      ch_r     <= '0;
      code_r   <= CODE_ZERO;
      dch_r    <= '0;
      load_r   <= 1'b0;
      ist_r    <= '0;
      imsk_r   <= '0;
      fail_q_r <= '0;
      fpwr_q_r <= 1'b0;
    end else begin
      chan_r   <= chan_nxt;
      cfg_r    <= cfg_nxt;
      ferr_r   <= ferr_nxt;
      tsel_r   <= tsel_nxt;
      tact_r   <= tact_nxt;
      tcnt_r   <= tcnt_nxt;
      tmo_r    <= tmo_nxt;
      scnt_r   <= scnt_nxt;
      ch_r     <= ch_nxt;
      code_r   <= code_nxt;
      dch_r    <= dch_nxt;
      load_r   <= load_nxt;
      ist_r    <= ist_nxt;
      imsk_r   <= imsk_nxt;
      fail_q_r <= fail_w;
      fpwr_q_r <= field_pwr_fail;
    end
  end

  // One checker per channel, strobed as its code goes out
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    lom_loop_chk u_chk (
      .pclk     (pclk),
      .presetn  (presetn),
      .chk_en   (load_r && dch_r == CH_W'(g)),
      .cmd_code (code_r),
      .readback (readback[g]),
      .deadband (deadband),
      .fail     (fail_w[g])
    );
  end

  assign dac_code     = code_r;
  assign dac_chan     = dch_r;
  assign dac_load     = load_r;
  assign comm_timeout = tmo_r;
  assign irq          = |(ist_r & imsk_r);

  // Checks
  logic [CH_W-1:0] last_ch_r;
  logic            seen_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ch_r <= '0;
      seen_r    <= 1'b0;
    end else if (load_r) begin
      last_ch_r <= dch_r;
      seen_r    <= 1'b1;
    end
  end

  property p_cfg_read;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_CFG_STAT)
      |=> stat_w[CFG_BIT] == $past(pwdata[CFG_BIT])
          && stat_w[TSEL_LSB +: TSEL_W] == $past(pwdata[TSEL_LSB +: TSEL_W])
          && stat_w[TACT_BIT] == $past(pwdata[TACT_BIT]);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config bit not read back"); // RULE1

  property p_force_err;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_CFG_STAT && pwdata[ERR_BIT]) |=> stat_w[ERR_BIT];
  endproperty
  a_force_err: assert property (p_force_err) else $error("forced error not shown"); // RULE3

  property p_zero_out;
    @(posedge pclk) disable iff (!presetn)
      (scnt_r == CNT_W'(STEP_CYC - 1) && tmo_r && !tact_r) |=> dac_load && dac_code == CODE_ZERO;
  endproperty
  a_zero_out: assert property (p_zero_out) else $error("timeout did not zero output"); // RULE10

  property p_hold_out;
    @(posedge pclk) disable iff (!presetn)
      (scnt_r == CNT_W'(STEP_CYC - 1) && cfg_r && (!tmo_r || tact_r))
      |=> dac_code == $past(chan_r[ch_r]);
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("held value not output"); // RULE10

  property p_chan_order;
    @(posedge pclk) disable iff (!presetn)
      (load_r && seen_r) |-> dch_r == CH_W'(last_ch_r + 1'b1);
  endproperty
  a_chan_order: assert property (p_chan_order) else $error("channel skipped"); // RULE7

  property p_attn;
    @(posedge pclk) disable iff (!presetn)
      (acc && is_data && !cfg_r) |-> pslverr ##1 ist_r[EV_ATTN];
  endproperty
  a_attn: assert property (p_attn) else $error("no attention when unconfigured"); // RULE13

  property p_status_bits;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && idx == IDX_CFG_STAT)
      |-> prdata[13:9] == '0 && !prdata[15] && prdata[FPWR_BIT] == field_pwr_fail
          && prdata[HWERR_BIT] == hw_err;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status bits wrong"); // RULE14

  property p_tsel_dflt;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> tsel_r == TSEL_RST;
  endproperty
  a_tsel_dflt: assert property (p_tsel_dflt) else $error("timeout default wrong"); // RULE11

  property p_fault_read;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && idx == IDX_LOOP_FAULT) |-> prdata[NCH-1:0] == fail_w
      && prdata[DATA_W-1:NCH] == '0;
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("loop fault word wrong"); // RULE9

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      ev[EV_TMO] |=> ist_r[EV_TMO] && (irq || !imsk_r[EV_TMO]);
  endproperty
  a_irq: assert property (p_irq) else $error("timeout event lost");

  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) $rose(tmo_r));
  c_attn:    cover property (@(posedge pclk) disable iff (!presetn) attn);
  c_open:    cover property (@(posedge pclk) disable iff (!presetn) ev[EV_OPEN]);
  c_hold:    cover property (@(posedge pclk) disable iff (!presetn) load_r && tmo_r && tact_r);
endmodule : lom_top

// >>> dv/lom_field_model.sv
`timescale 1ns/1ps
// Field side of the converter link: every loop reads back the last code it was sent.
// A broken loop returns the inverse, so for codes away from mid-scale the error is far outside any sane deadband.
module lom_field_model (
  // Clock and reset
  input  wire logic                                        pclk,
  input  wire logic                                        presetn,
  // Converter link
  input  wire logic [lom_pkg::DAC_W-1:0]                   dac_code,
  input  wire logic [lom_pkg::CH_W-1:0]                    dac_chan,
  input  wire logic                                        dac_load,
  // Fault injection, one bit per loop
  input  wire logic [lom_pkg::NCH-1:0]                     brk,
  // Measured codes
  output logic      [lom_pkg::NCH-1:0][lom_pkg::DAC_W-1:0] readback
);
  import lom_pkg::*;
  logic [NCH-1:0][DAC_W-1:0] held_r;

  // Latch the code at each load strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r <= '0;
    end else if (dac_load) begin
      held_r[dac_chan] <= dac_code;
    end
  end

  // Readback follows the held code unless the loop is broken
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      readback[i] = brk[i] ? ~held_r[i] : held_r[i];
    end
  end
endmodule : lom_field_model

// >>> dv/lom_top_bench.sv
`timescale 1ns/1ps
module lom_top_bench;
  import lom_pkg::*;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic                      fpwr, dac_load, comm_timeout, irq, seen;
  logic [ADDR_W-1:0]         paddr;
  logic [DATA_W-1:0]         pwdata, prdata, rdat;
  logic [3:0]                hwf;
  logic [NCH-1:0]            brk;
  logic [DAC_W-1:0]          dac_code;
  logic [CH_W-1:0]           dac_chan, last_ch;
  logic [NCH-1:0][DAC_W-1:0] readback;
  int                        err_count, cmp_count, gap;

  // Small ms count keeps timeouts short: 62 ms is 496 cycles, a step 24
  lom_top #(.CYC_PER_MS(8)) lom_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .logic_load_fail(hwf[0]), .nv_csum_bad(hwf[1]), .prog_csum_bad(hwf[2]),
    .mem_diag_fail(hwf[3]), .field_pwr_fail(fpwr), .dac_code(dac_code),
    .dac_chan(dac_chan), .dac_load(dac_load), .readback(readback),
    .deadband(14'h0010), .comm_timeout(comm_timeout), .irq(irq));

  lom_field_model lom_field_model_inst (
    .pclk(pclk), .presetn(presetn), .dac_code(dac_code), .dac_chan(dac_chan),
    .dac_load(dac_load), .brk(brk), .readback(readback));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // One APB transfer; ready, read data and error are all taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Callers then look at outputs that the completing edge has settled
    @(negedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rdat, exp);
  endtask : rd

  function automatic logic [DAC_W-1:0] code(input int i);
    return 14'h1000 + 14'(i) * 14'h0111;
  endfunction : code

  // Wait, bounded, for the load strobe of one channel
  task automatic load_of(input int ch);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (!(dac_load === 1'b1 && dac_chan === 3'(ch)) && n < 400);
  endtask : load_of

  // Cycles from the last access to the timeout flag, with a small tolerance
  task automatic tmo(input int exp);
    int n;
    n = 0;
    while (comm_timeout !== 1'b1 && n < 2200) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n >= exp - 8 && n <= exp + 8), 32'h1);
  endtask : tmo

  // Strobes must come every step, channels in round-robin order
  always @(negedge pclk) begin
    if (dac_load === 1'b1) begin
      if (seen) begin
        chk(gap, 24);
        chk(dac_chan, 3'(last_ch + 3'h1));
      end
      seen = 1'b1;
      gap = 1;
      last_ch = dac_chan;
    end else begin
      gap++;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Hang guard, well above the expected run length
  initial begin
    #400_000;
    err_count++;
    close_out;
  end

  initial begin
    {presetn, psel, penable, pwrite, fpwr, seen} = '0;
    {paddr, pwdata, hwf, brk, last_ch} = '0;
    {err_count, cmp_count, gap} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h034, 32'h0);
    rd(12'h030, 32'h0);
    // Attention while unconfigured, then interrupt mask and clear
    apb(1'b0, 12'h000, '0);
    chk(rerr, 1'b1);
    rd(12'h040, 32'h2);
    chk(irq, 1'b0);
    apb(1'b1, 12'h044, 32'h2);
    chk(irq, 1'b1);
    apb(1'b1, 12'h040, 32'h2);
    chk(irq, 1'b0);
    apb(1'b0, 12'h080, '0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    // Configure: hold on timeout, 62 ms; upper bits must not stick
    apb(1'b1, 12'h034, 32'h0000ff3d);
    rd(12'h034, 32'h3d);
    for (int i = 0; i < NCH; i++) apb(1'b1, 12'(4 * i), 32'hffffc000 | code(i));
    rd(12'h008, 32'(code(2)));
    rd(12'h020, 32'h0);
    for (int i = 0; i < NCH; i++) begin
      load_of(i);
      chk(dac_code, code(i));
    end
    repeat (200) @(posedge pclk);
    rd(12'h030, 32'h0);
    brk <= 8'h08;
    load_of(3);
    rd(12'h030, 32'h08);
    brk <= 8'h00;
    load_of(3);
    rd(12'h030, 32'h0);
    apb(1'b1, 12'h040, 32'hf);
    // Force error and hardware faults
    apb(1'b1, 12'h034, 32'h3f);
    rd(12'h034, 32'h3f);
    apb(1'b1, 12'h034, 32'h3d);
    for (int k = 0; k < 4; k++) begin
      hwf <= 4'(1 << k);
      rd(12'h034, 32'h13f);
    end
    hwf <= 4'h0;
    fpwr <= 1'b1;
    rd(12'h034, 32'h403d);
    rd(12'h040, 32'h8);
    fpwr <= 1'b0;
    apb(1'b1, 12'h040, 32'hf);
    // Timeout with hold action, 62 ms
    tmo(496);
    load_of(0);
    chk(dac_code, code(0));
    rd(12'h034, 32'h3f);
    rd(12'h040, 32'h1);
    // Timeout with zero action, 125 ms
    apb(1'b1, 12'h034, 32'h19);
    tmo(1000);
    load_of(1);
    chk(dac_code, 14'h0);
    rd(12'h034, 32'h1b);
    load_of(1);
    chk(dac_code, code(1));
    // Timeout with hold action, 250 ms
    apb(1'b1, 12'h034, 32'h35);
    tmo(2000);
    load_of(4);
    chk(dac_code, code(4));
    // Unconfiguring drives zero codes
    apb(1'b1, 12'h034, 32'h0);
    load_of(2);
    chk(dac_code, 14'h0);
    close_out;
  end
endmodule : lom_top_bench
